// file: core/rcl_top.sv
// Contract
// - four latch bytes configure device at reset
// - byte map: ports 0-3, ports 4-6 and 12, port 15 and reset enable, boot options
// - one mode drives every pin of port
// - mode codes: analog, digital, pullup, pulldown
// - enable bit makes shared pin external reset
// - boot clock 12 MHz or 48 MHz
// - debug select: JTAG5, JTAG4, SWD, none
// - ECC enable uses extra flash area
// - byte 3 nibble sets clock phase delay
// - correct single, detect double per 8 bytes
`timescale 1ns/1ps
`default_nettype none
`include "rcl_consts.svh"
module rcl_top
   import rcl_pkg::*;
#(
   parameter logic XRST_DEFAULT = 1'b0
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic shared_reset_pin,
   output logic ext_reset_req,
   output logic ext_reset_pin_enable,
   output var rcl_drive_t pin_mode [`RCL_PORTS][`RCL_PINS],
   output logic boot_clock_speed,
   output logic [5:0] boot_clk_mhz,
   output var rcl_dbg_en_t debug_en,
   output logic flash_ecc_enable,
   output logic ecc_area_for_data,
   output logic [3:0] digital_clock_phase_delay,
   output logic config_valid,
   input wire logic fw_in_valid,
   input wire rcl_ecc_word_t fw_in,
   output logic fw_out_valid,
   output logic [63:0] fw_out_data,
   output logic fw_single_err,
   output logic fw_double_err,
   output logic ecc_err_event
);

   // nonvolatile contents: not touched by reset, start at factory state
   logic [31:0] latch_q = `RCL_LATCH_DEFAULT | {8'h00, XRST_DEFAULT, 23'h000000};
   logic [15:0] wcnt_q = 16'h0000;
   logic [31:0] applied_q;
   rcl_latch_t cfg;
   rcl_state_t state_q;
   logic is_latch;
   logic [7:0] latch_byte;
   logic [7:0] rd_mux;
   logic [1:0] ecc_stat_q;
   logic [1:0] ecc_clr;
   logic [6:0] syn;
   logic par_bad;
   logic ext_rst_q;

   assign cfg = rcl_latch_t'(applied_q);
   assign is_latch = (reg_addr[7:2] == 6'h00);
   assign latch_byte = latch_q[{reg_addr[1:0], 3'h0} +: 8];

   // programmer writes; an unchanged byte is skipped to spare wear
   always_ff @(posedge clk)
   begin
      if (reg_wr && is_latch && (latch_byte != reg_wdata))
      begin
         latch_q[{reg_addr[1:0], 3'h0} +: 8] <= reg_wdata;
         wcnt_q <= wcnt_q + 16'h0001;
      end
   end

   // snapshot taken on the first edge after reset release
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= RCL_ST_LOAD;
         applied_q <= `RCL_LATCH_DEFAULT;
      end
      else
      begin
         unique case (state_q)
            RCL_ST_LOAD:
            begin
               applied_q <= latch_q;
               state_q <= RCL_ST_HOLD;
            end
            RCL_ST_HOLD:
            begin
               applied_q <= applied_q;
            end
         endcase
      end
   end

   assign config_valid = (state_q == RCL_ST_HOLD);

   for (genvar p = 0; p < `RCL_PINS; p++)
   begin : g_pin
      assign pin_mode[0][p] = cfg.mode_p0;
      assign pin_mode[1][p] = cfg.mode_p1;
      assign pin_mode[2][p] = cfg.mode_p2;
      assign pin_mode[3][p] = cfg.mode_p3;
      assign pin_mode[4][p] = cfg.mode_p4;
      assign pin_mode[5][p] = cfg.mode_p5;
      assign pin_mode[6][p] = cfg.mode_p6;
      assign pin_mode[7][p] = cfg.mode_p12;
      assign pin_mode[8][p] = cfg.mode_p15;
   end

   assign boot_clock_speed = cfg.boot_clock_speed;
   assign boot_clk_mhz = cfg.boot_clock_speed ? `RCL_BOOT_FAST_MHZ : `RCL_BOOT_SLOW_MHZ;
   assign flash_ecc_enable = cfg.flash_ecc_enable;
   assign ecc_area_for_data = !cfg.flash_ecc_enable;
   assign digital_clock_phase_delay = cfg.digital_clock_phase_delay;
   assign ext_reset_pin_enable = cfg.ext_reset_pin_enable;

   always_comb
   begin
      debug_en = '0;
      unique case (cfg.debug_port_select)
         RCL_DBG_JTAG5: debug_en.jtag5 = 1'b1;
         RCL_DBG_JTAG4: debug_en.jtag4 = 1'b1;
         RCL_DBG_SWD: debug_en.swd = 1'b1;
         RCL_DBG_OFF: debug_en.off = 1'b1;
      endcase
   end

   // low level on the shared pin resets only when enabled; else it is a plain pin
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         ext_rst_q <= 1'b0;
      else
         ext_rst_q <= cfg.ext_reset_pin_enable && !shared_reset_pin;
   end
   assign ext_reset_req = ext_rst_q;

   // hamming syndrome over positions 1..71, check bits at powers of two
   function automatic logic [6:0] ecc_syndrome(input rcl_ecc_word_t w);
      logic [6:0] s;
      int j;
      int k;
      s = 7'h00;
      j = 0;
      k = 0;
      for (int pos = 1; pos < 72; pos++)
      begin
         if ((pos & (pos - 1)) == 0)
         begin
            if (w.check[k]) s = s ^ 7'(pos);
            k++;
         end
         else
         begin
            if (w.data[j]) s = s ^ 7'(pos);
            j++;
         end
      end
      return s;
   endfunction

   // flip the data bit that sits at the syndrome position
   function automatic logic [63:0] ecc_fix(input logic [63:0] d, input logic [6:0] s);
      logic [63:0] r;
      int j;
      r = d;
      j = 0;
      for (int pos = 1; pos < 72; pos++)
      begin
         if ((pos & (pos - 1)) != 0)
         begin
            if (7'(pos) == s) r[j] = !r[j];
            j++;
         end
      end
      return r;
   endfunction

   assign syn = ecc_syndrome(fw_in);
   assign par_bad = ^{fw_in.check, fw_in.data};

   // one-stage check of each 8-byte row; passes raw data while ECC is off
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fw_out_valid <= 1'b0;
         fw_out_data <= 64'h0000_0000_0000_0000;
         fw_single_err <= 1'b0;
         fw_double_err <= 1'b0;
      end
      else
      begin
         fw_out_valid <= fw_in_valid;
         fw_single_err <= 1'b0;
         fw_double_err <= 1'b0;
         fw_out_data <= fw_in.data;
         if (fw_in_valid && cfg.flash_ecc_enable)
         begin
            if (par_bad)
            begin
               fw_single_err <= 1'b1;
               fw_out_data <= ecc_fix(fw_in.data, syn);
            end
            else if (syn != 7'h00)
               fw_double_err <= 1'b1;
         end
      end
   end
   assign ecc_err_event = fw_single_err || fw_double_err;

   // sticky error status, write one to clear; a new error beats the clear
   assign ecc_clr = (reg_wr && reg_addr == `RCL_OFF_ECC_STAT) ? reg_wdata[1:0] : 2'h0;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         ecc_stat_q <= 2'h0;
      else
         ecc_stat_q <= (ecc_stat_q & ~ecc_clr) | {fw_double_err, fw_single_err};
   end

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rd_mux = 8'h00;
      if (is_latch)
         rd_mux = latch_byte;
      else if (reg_addr >= `RCL_OFF_APPLIED0 && reg_addr <= `RCL_OFF_APPLIED3)
         rd_mux = applied_q[{reg_addr[1:0], 3'h0} +: 8];
      else if (reg_addr == `RCL_OFF_WCNT_LO)
         rd_mux = wcnt_q[7:0];
      else if (reg_addr == `RCL_OFF_WCNT_HI)
         rd_mux = wcnt_q[15:8];
      else if (reg_addr == `RCL_OFF_ECC_STAT)
         rd_mux = {6'h00, ecc_stat_q};
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   property p_load;
      (state_q == RCL_ST_LOAD) |=> (applied_q == $past(latch_q)) && config_valid;
   endproperty
   a_load: assert property (p_load) else $error("latch snapshot not taken at release");

   property p_hold;
      config_valid |=> $stable(applied_q) && config_valid;
   endproperty
   a_hold: assert property (p_hold) else $error("applied configuration changed");

   property p_map;
      config_valid |-> (pin_mode[7][3] == rcl_drive_t'(applied_q[15:14]))
         && (pin_mode[8][1] == rcl_drive_t'(applied_q[17:16]))
         && (ext_reset_pin_enable == applied_q[`RCL_XRST_BIT]);
   endproperty
   a_map: assert property (p_map) else $error("latch byte map mismatch");

   property p_same;
      (pin_mode[0][7] == pin_mode[0][0]) && (pin_mode[5][6] == pin_mode[5][1]);
   endproperty
   a_same: assert property (p_same) else $error("pins of one port differ");

   property p_decode;
      config_valid |-> pin_mode[3][2] == rcl_drive_t'(applied_q[7:6]);
   endproperty
   a_decode: assert property (p_decode) else $error("port mode decode wrong");

   property p_xrst;
      ##1 1'b1 |-> ext_reset_req == ($past(ext_reset_pin_enable) && !$past(shared_reset_pin));
   endproperty
   a_xrst: assert property (p_xrst) else $error("external reset request wrong");

   property p_speed;
      boot_clk_mhz == (applied_q[24] ? `RCL_BOOT_FAST_MHZ : `RCL_BOOT_SLOW_MHZ);
   endproperty
   a_speed: assert property (p_speed) else $error("boot clock rate wrong");

   property p_dbg;
      $onehot(debug_en) && (debug_en.swd == (applied_q[26:25] == 2'b10));
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug port select wrong");

   property p_ecc_off;
      (fw_in_valid && !flash_ecc_enable) |=> !ecc_err_event && (fw_out_data == $past(fw_in.data));
   endproperty
   a_ecc_off: assert property (p_ecc_off) else $error("ECC acted while disabled");

   property p_ecc_on;
      (fw_in_valid && flash_ecc_enable) |=> fw_out_valid && !(fw_single_err && fw_double_err)
         ##1 (ecc_stat_q[`RCL_ECC_SINGLE_BIT] || !$past(fw_single_err));
   endproperty
   a_ecc_on: assert property (p_ecc_on) else $error("ECC result or status wrong");

   property p_wear;
      (reg_wr && is_latch && reg_wdata == latch_byte) |=> $stable(wcnt_q);
   endproperty
   a_wear: assert property (p_wear) else $error("identical write counted");

   property p_phase;
      digital_clock_phase_delay == applied_q[31:28];
   endproperty
   a_phase: assert property (p_phase) else $error("phase delay field wrong");

endmodule
`default_nettype wire

// file: core/rcl_consts.svh
`ifndef RCL_CONSTS_SVH
`define RCL_CONSTS_SVH
// register offsets on the plain register port
`define RCL_OFF_LATCH3 8'h03
`define RCL_OFF_APPLIED0 8'h04
`define RCL_OFF_APPLIED3 8'h07
`define RCL_OFF_WCNT_LO 8'h08
`define RCL_OFF_WCNT_HI 8'h09
`define RCL_OFF_ECC_STAT 8'h0A
// field positions
`define RCL_ECC_SINGLE_BIT 0
`define RCL_ECC_DOUBLE_BIT 1
`define RCL_XRST_BIT 23
// factory contents {byte3, byte2, byte1, byte0}, reset-pin bit added by parameter
`define RCL_LATCH_DEFAULT 32'h0200_0000
// boot clock rates in MHz
`define RCL_BOOT_SLOW_MHZ 6'h0C
`define RCL_BOOT_FAST_MHZ 6'h30
// array shape: ports 0..6, 12, 15 and eight pins each
`define RCL_PORTS 9
`define RCL_PINS 8
`endif

// file: core/rcl_pkg.sv
`default_nettype none
package rcl_pkg;
   typedef enum logic [1:0] {
      RCL_DRV_HIZ_ANALOG = 2'b00,
      RCL_DRV_HIZ_DIGITAL = 2'b01,
      RCL_DRV_PULL_UP = 2'b10,
      RCL_DRV_PULL_DOWN = 2'b11
   } rcl_drive_t;
   typedef enum logic [1:0] {
      RCL_DBG_JTAG5 = 2'b00,
      RCL_DBG_JTAG4 = 2'b01,
      RCL_DBG_SWD = 2'b10,
      RCL_DBG_OFF = 2'b11
   } rcl_dbg_t;
   typedef enum logic [0:0] {
      RCL_ST_LOAD = 1'b0,
      RCL_ST_HOLD = 1'b1
   } rcl_state_t;
   // the four latch bytes, byte 3 in the top bits
   typedef struct packed {
      logic [3:0] digital_clock_phase_delay;
      logic flash_ecc_enable;
      rcl_dbg_t debug_port_select;
      logic boot_clock_speed;
      logic ext_reset_pin_enable;
      logic [4:0] rsvd;
      rcl_drive_t mode_p15;
      rcl_drive_t mode_p12;
      rcl_drive_t mode_p6;
      rcl_drive_t mode_p5;
      rcl_drive_t mode_p4;
      rcl_drive_t mode_p3;
      rcl_drive_t mode_p2;
      rcl_drive_t mode_p1;
      rcl_drive_t mode_p0;
   } rcl_latch_t;
   typedef struct packed {
      logic [7:0] check;
      logic [63:0] data;
   } rcl_ecc_word_t;
   typedef struct packed {
      logic jtag5;
      logic jtag4;
      logic swd;
      logic off;
   } rcl_dbg_en_t;
endpackage
`default_nettype wire

// file: dv/rcl_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcl_prog_model
(
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   // bus idles with both strobes low
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // one write strobe, then an idle edge so no strobe is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
      @(posedge clk);
   endtask

   task automatic burn(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] cur;
      rd(a, cur);
      if (cur !== d)
      begin
         wr(a, d);
      end
   endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rcl_pkg::*;
   typedef struct packed {
      logic [31:0] lat;
      logic [3:0] dbg;
      logic [5:0] mhz;
   } rcl_row_t;
   logic clk, arst_n, reg_wr, reg_rd, shared_reset_pin, ext_reset_req, ext_reset_pin_enable;
   logic boot_clock_speed, flash_ecc_enable, ecc_area_for_data, config_valid, fw_in_valid;
   logic fw_out_valid, fw_single_err, fw_double_err, ecc_err_event;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [5:0] boot_clk_mhz;
   logic [3:0] digital_clock_phase_delay;
   logic [63:0] fw_out_data;
   rcl_drive_t pin_mode [9][8];
   rcl_dbg_en_t debug_en;
   rcl_ecc_word_t fw_in;
   int err_total, checks;
   // every mode code and debug code appears in some row
   rcl_row_t rows [4] = '{'{32'h5082_1BE4, 4'h8, 6'h0C}, '{32'hAB03_E41B, 4'h4, 6'h30},
      '{32'h0401_55AA, 4'h2, 6'h0C}, '{32'hF680_00FF, 4'h1, 6'h0C}};

   rcl_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shared_reset_pin(shared_reset_pin),
      .ext_reset_req(ext_reset_req), .ext_reset_pin_enable(ext_reset_pin_enable), .pin_mode(pin_mode),
      .boot_clock_speed(boot_clock_speed), .boot_clk_mhz(boot_clk_mhz), .debug_en(debug_en),
      .flash_ecc_enable(flash_ecc_enable), .ecc_area_for_data(ecc_area_for_data),
      .digital_clock_phase_delay(digital_clock_phase_delay), .config_valid(config_valid),
      .fw_in_valid(fw_in_valid), .fw_in(fw_in), .fw_out_valid(fw_out_valid), .fw_out_data(fw_out_data),
      .fw_single_err(fw_single_err), .fw_double_err(fw_double_err), .ecc_err_event(ecc_err_event));
   rcl_prog_model prog (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // 10 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t %s seen %0h exp %0h", $time, what, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("errors %0d checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // whole applied configuration against the latch word it came from
   task automatic check_cfg(input logic [31:0] lat, input logic [3:0] dbg, input logic [5:0] mhz);
      int sh;
      for (int p = 0; p < 9; p++)
      begin
         sh = (p < 7) ? 2 * p : ((p == 7) ? 14 : 16);
         for (int q = 0; q < 8; q++)
         begin
            chk(pin_mode[p][q], lat[sh +: 2], "pin mode");
         end
      end
      chk(ext_reset_pin_enable, lat[23], "reset pin enable");
      chk(boot_clock_speed, lat[24], "boot speed");
      chk(boot_clk_mhz, mhz, "boot clock");
      chk(debug_en, dbg, "debug select");
      chk(flash_ecc_enable, lat[27], "ecc enable");
      chk(ecc_area_for_data, !lat[27], "ecc area use");
      chk(digital_clock_phase_delay, lat[31:28], "phase delay");
   endtask

   task automatic pulse_reset();
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask

   // one row in, checked in the cycle it stands
   task automatic ecc_row(input logic [71:0] w, input logic [63:0] dat, input logic s, input logic dd);
      fw_in <= w;
      fw_in_valid <= 1'b1;
      @(posedge clk);
      fw_in_valid <= 1'b0;
      @(negedge clk);
      chk(fw_out_valid, 1'b1, "row valid");
      chk(fw_out_data, dat, "row data");
      chk(fw_single_err, s, "single flag");
      chk(fw_double_err, dd, "double flag");
      chk(ecc_err_event, s | dd, "error event");
      @(posedge clk);
   endtask

   initial
   begin
      logic [7:0] d, c0;
      err_total = 0;
      checks = 0;
      arst_n = 1'b0;
      shared_reset_pin = 1'b1;
      fw_in_valid = 1'b0;
      fw_in = '0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk(config_valid, 1'b0, "valid in reset");
      check_cfg(32'h0200_0000, 4'h4, 6'h0C);
      @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
         for (int b = 0; b < 4; b++)
         begin
            prog.burn(8'(b), rows[i].lat[8 * b +: 8]);
         end
         pulse_reset();
         @(negedge clk);
         chk(config_valid, 1'b1, "valid after release");
         check_cfg(rows[i].lat, rows[i].dbg, rows[i].mhz);
         // pin low asks reset only when enabled
         @(posedge clk);
         shared_reset_pin <= 1'b0;
         @(posedge clk);
         @(negedge clk);
         chk(ext_reset_req, rows[i].lat[23], "reset request");
         @(posedge clk);
         shared_reset_pin <= 1'b1;
         // zero codeword with one, then two data bits flipped
         ecc_row(72'h1, rows[i].lat[27] ? 64'h0 : 64'h1, rows[i].lat[27], 1'b0);
         ecc_row(72'h3, 64'h3, 1'b0, rows[i].lat[27]);
         prog.rd(8'h0A, d);
         chk(d, {6'h00, {2{rows[i].lat[27]}}}, "ecc status");
         prog.wr(8'h0A, 8'h03);
         prog.rd(8'h0A, d);
         chk(d, 8'h00, "status cleared");
      end
      // rewrites wait for the next reset
      prog.rd(8'h08, c0);
      prog.wr(8'h00, 8'hFF);
      prog.rd(8'h08, d);
      chk(d, c0, "count on same value");
      prog.wr(8'h00, 8'h7E);
      prog.rd(8'h00, d);
      chk(d, 8'h7E, "latch readback");
      @(negedge clk);
      chk(reg_rdata, 8'h00, "read data dropped");
      @(posedge clk);
      prog.rd(8'h08, d);
      chk(d, c0 + 8'h01, "count on change");
      prog.rd(8'h04, d);
      chk(d, 8'hFF, "applied byte held");
      prog.rd(8'h07, d);
      chk(d, 8'hF6, "applied top byte held");
      prog.rd(8'h09, d);
      chk(d, 8'h00, "count high byte");
      prog.rd(8'h40, d);
      chk(d, 8'h00, "unmapped read");
      @(negedge clk);
      check_cfg(rows[3].lat, rows[3].dbg, rows[3].mhz);
      @(posedge clk);
      pulse_reset();
      @(negedge clk);
      chk(pin_mode[0][0], 2'h2, "new mode applied");
      chk(pin_mode[3][7], 2'h1, "new mode applied");
      tally_and_finish();
   end

   // cut a hang short well beyond the expected run
   initial
   begin
      #1_000_000;
      err_total++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
